//--- hw/flash_cmd_pkg.sv
// constants and rule summary for the serial flash command front end
//
// Summary of operation
// - serial output floats until read data due
// - ignore commands until chip select falls
// - clock idle level at select picks mode
// - no response while power-on reset active
// - after delay: select high standby, low active
// - address layout and per-opcode dummy byte counts
package flash_cmd_pkg;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int SYS_CLK_MHZ = 100;
   localparam int READ_AFTER_POWER_DELAY_US = 70;
   localparam int PROGRAM_AFTER_POWER_DELAY_MS = 3;
   // least time, whole microseconds times whole MHz is exact
   localparam int READ_AFTER_POWER_DELAY_CYC = READ_AFTER_POWER_DELAY_US * SYS_CLK_MHZ;
   // longest time, exact in cycles as well
   localparam int PROGRAM_AFTER_POWER_DELAY_CYC = PROGRAM_AFTER_POWER_DELAY_MS * 1000 * SYS_CLK_MHZ;
   localparam int POWER_CNT_W = 19;

   // -----------------------------------------------------------------
   // frame layout
   // -----------------------------------------------------------------
   localparam int ADDR_BYTES = 3;
   localparam int PAGE_ADDR_W = 12;
   localparam int BYTE_ADDR_W = 9;
   localparam int PAGE_ADDR_MSB = 20;
   localparam int BYTE_ADDR_MSB = 8;
   localparam logic [3:0] BYTE_CNT_MAX = 4'hF;

   // -----------------------------------------------------------------
   // opcodes that need more than a bare header
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_READ_LOW_POWER = 8'h01;
   localparam logic [7:0] OP_READ_LOW_FREQ = 8'h03;
   localparam logic [7:0] OP_READ_FAST = 8'h0B;
   localparam logic [7:0] OP_READ_FASTEST = 8'h1B;
   localparam logic [7:0] OP_READ_ID = 8'h9F;
   localparam logic [7:0] OP_PAGE_READ = 8'hD2;
   localparam logic [7:0] OP_BUF1_READ = 8'hD4;
   localparam logic [7:0] OP_BUF2_READ = 8'hD6;
   localparam logic [7:0] OP_STATUS_READ = 8'hD7;
   localparam logic [2:0] DUMMY_PAGE_READ = 3'h4;
   localparam logic [2:0] DUMMY_BUF_READ = 3'h1;
   localparam logic [2:0] DUMMY_FAST = 3'h1;
   localparam logic [2:0] DUMMY_FASTEST = 3'h2;

   // power state as seen by the host
   typedef enum logic [1:0] {PWR_RESET, PWR_STANDBY, PWR_ACTIVE} power_state_t;

endpackage

//--- hw/level_sync.sv
// two-stage synchroniser for levels entering the system clock domain
module level_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // level in, synchronised level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule // level_sync

//--- hw/flash_cmd_front.sv
// serial flash command framing and power-on behaviour, device side
module flash_cmd_front
   import flash_cmd_pkg::*;
#(
   parameter int READ_DELAY_CYC = READ_AFTER_POWER_DELAY_CYC,
   parameter int PROGRAM_DELAY_CYC = PROGRAM_AFTER_POWER_DELAY_CYC
) (
   // system clock, power-on/pin reset, clock enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // serial link pins
   input wire logic serial_clk,
   input wire logic chip_select_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_oe,
   // read data supplied by the memory core
   input wire logic [7:0] read_byte,
   // decoded command towards the memory core
   output logic cmd_valid,
   output logic [7:0] cmd_opcode,
   output logic [PAGE_ADDR_W-1:0] cmd_page_addr,
   output logic [BYTE_ADDR_W-1:0] cmd_byte_addr,
   output logic frame_end,
   // power and mode status
   output logic read_ready,
   output logic program_ready,
   output power_state_t power_state,
   output logic spi_mode3
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic cs_sync, sck_sync, cmd_tgl_sync;
   logic cs_act_sync;
   logic cs_prev_r, cmd_tgl_prev_r, cs_high_seen_r, frame_en_r;
   logic [POWER_CNT_W-1:0] power_cnt_r;
   logic [7:0] read_hold_r;
   logic link_rst;
   logic [2:0] bit_cnt_r;
   logic [3:0] byte_cnt_r;
   logic [6:0] shift_r;
   logic [7:0] rx_byte, opcode_r;
   logic [23:0] addr_r;
   logic cmd_tgl_r, data_phase;
   logic [3:0] hdr_bytes, first_data;

   // opcode properties
   function automatic logic has_addr(input logic [7:0] op);
      return !(op == OP_READ_ID || op == OP_STATUS_READ);
   endfunction

   function automatic logic is_read(input logic [7:0] op);
      unique case (op)
         OP_READ_LOW_POWER, OP_READ_LOW_FREQ, OP_READ_FAST, OP_READ_FASTEST,
         OP_READ_ID, OP_PAGE_READ, OP_BUF1_READ, OP_BUF2_READ, OP_STATUS_READ: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] dummy_bytes(input logic [7:0] op);
      unique case (op)
         OP_PAGE_READ: return DUMMY_PAGE_READ;
         OP_BUF1_READ, OP_BUF2_READ: return DUMMY_BUF_READ;
         OP_READ_FAST: return DUMMY_FAST;
         OP_READ_FASTEST: return DUMMY_FASTEST;
         default: return 3'h0;
      endcase
   endfunction

   // -----------------------------------------------------------------
   // pin synchronisers into the system domain
   // -----------------------------------------------------------------
   level_sync #(.W(3)) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .d({~chip_select_n, serial_clk, cmd_tgl_r}),
      .q({cs_act_sync, sck_sync, cmd_tgl_sync})
   );

   // select is carried active high through the stages so their reset
   // value reads as deselected and no false select fall follows reset
   assign cs_sync = !cs_act_sync;

   // -----------------------------------------------------------------
   // power-up delay
   // -----------------------------------------------------------------
   // counts from reset release; saturates once the longer delay ends
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_cnt_r <= '0;
      end else if (clk_en && power_cnt_r < POWER_CNT_W'(PROGRAM_DELAY_CYC)) begin
         power_cnt_r <= power_cnt_r + 1'b1;
      end
   end

   assign read_ready = power_cnt_r >= POWER_CNT_W'(READ_DELAY_CYC);
   assign program_ready = power_cnt_r >= POWER_CNT_W'(PROGRAM_DELAY_CYC);

   // standby or active follows chip select once the delay is over
   always_comb begin
      if (!program_ready) begin
         power_state = PWR_RESET;
      end else if (cs_sync) begin
         power_state = PWR_STANDBY;
      end else begin
         power_state = PWR_ACTIVE;
      end
   end

   // -----------------------------------------------------------------
   // link enable: needs a high select seen after reset, so a select
   // already low at reset release is never taken as a frame start
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_high_seen_r <= 1'b0;
         frame_en_r <= 1'b0;
      end else if (clk_en) begin
         if (cs_sync) begin
            cs_high_seen_r <= 1'b1;
         end
         // only changes while select is high so the link sees no glitch mid-frame
         if (cs_sync) begin
            frame_en_r <= cs_high_seen_r && read_ready;
         end
      end
   end

   // -----------------------------------------------------------------
   // mode detect and frame end
   // -----------------------------------------------------------------
   // the clock level sampled at the select fall is the idle level
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cs_prev_r <= 1'b1;
         spi_mode3 <= 1'b0;
         frame_end <= 1'b0;
      end else if (clk_en) begin
         cs_prev_r <= cs_sync;
         frame_end <= cs_sync && !cs_prev_r && frame_en_r;
         if (!cs_sync && cs_prev_r) begin
            spi_mode3 <= sck_sync;
         end
      end
   end

   // -----------------------------------------------------------------
   // read data hold: only reloaded while select is high, so it is
   // static for the whole frame and safe to read on the link clock
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         read_hold_r <= 8'h00;
      end else if (clk_en && cs_sync) begin
         read_hold_r <= read_byte;
      end
   end

   // -----------------------------------------------------------------
   // command hand-over from link to system domain
   // -----------------------------------------------------------------
   // link fields are stable for at least a byte time after the toggle
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cmd_tgl_prev_r <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_opcode <= 8'h00;
         cmd_page_addr <= '0;
         cmd_byte_addr <= '0;
      end else if (clk_en) begin
         cmd_tgl_prev_r <= cmd_tgl_sync;
         cmd_valid <= cmd_tgl_sync != cmd_tgl_prev_r;
         if (cmd_tgl_sync != cmd_tgl_prev_r) begin
            cmd_opcode <= opcode_r;
            cmd_page_addr <= addr_r[PAGE_ADDR_MSB -: PAGE_ADDR_W];
            cmd_byte_addr <= addr_r[BYTE_ADDR_MSB -: BYTE_ADDR_W];
         end
      end
   end

   // -----------------------------------------------------------------
   // link domain: frame counters, cleared by select high or reset
   // -----------------------------------------------------------------
   assign link_rst = chip_select_n || !frame_en_r;
   assign rx_byte = {shift_r, serial_in};
   assign hdr_bytes = has_addr(opcode_r) ? 4'(ADDR_BYTES + 1) : 4'h1;
   assign first_data = hdr_bytes + {1'b0, dummy_bytes(opcode_r)};
   assign data_phase = is_read(opcode_r) && byte_cnt_r >= first_data;

   // bits sampled on the rising edge in both modes
   always_ff @(posedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt_r <= 3'h0;
         byte_cnt_r <= 4'h0;
         shift_r <= 7'h00;
      end else begin
         bit_cnt_r <= bit_cnt_r + 1'b1;
         shift_r <= rx_byte[6:0];
         if (bit_cnt_r == 3'h7 && byte_cnt_r != BYTE_CNT_MAX) begin
            byte_cnt_r <= byte_cnt_r + 1'b1;
         end
      end
   end

   // opcode, address and hand-over toggle survive the select rising so
   // the system side can still read them; only reset clears them
   always_ff @(posedge serial_clk or negedge reset_n) begin
      if (!reset_n) begin
         opcode_r <= 8'h00;
         addr_r <= 24'h000000;
         cmd_tgl_r <= 1'b0;
      end else if (!link_rst && bit_cnt_r == 3'h7) begin
         if (byte_cnt_r == 4'h0) begin
            opcode_r <= rx_byte;
         end else if (byte_cnt_r <= 4'(ADDR_BYTES)) begin
            addr_r <= {addr_r[15:0], rx_byte};
         end
         // header complete: opcode alone or opcode plus address
         if (byte_cnt_r == 4'h0 ? !has_addr(rx_byte) : byte_cnt_r == 4'(ADDR_BYTES) && has_addr(opcode_r)) begin
            cmd_tgl_r <= !cmd_tgl_r;
         end
      end
   end

   // -----------------------------------------------------------------
   // serial output: launched on the falling edge, floating otherwise
   // -----------------------------------------------------------------
   always_ff @(negedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         serial_out <= 1'b0;
         serial_out_oe <= 1'b0;
      end else begin
         serial_out_oe <= data_phase;
         serial_out <= data_phase ? read_hold_r[~bit_cnt_r] : 1'b0;
      end
   end

endmodule // flash_cmd_front

//--- bench/flash_cmd_checker.sv
// port-level assertions for the serial flash command front end
module flash_cmd_checker import flash_cmd_pkg::*;
#(
   parameter int READ_DELAY_CYC = 20,
   parameter int PROGRAM_DELAY_CYC = 50
) (
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // link pins
   input wire logic chip_select_n,
   input wire logic serial_out_oe,
   // decoded strobes and status
   input wire logic cmd_valid,
   input wire logic frame_end,
   input wire logic read_ready,
   input wire logic program_ready,
   input wire power_state_t power_state,
   input wire logic spi_mode3
);
   timeunit 1ns;
   timeprecision 100ps;
   int cyc_r;
   // enabled cycles since reset; saturates so a long run never wraps
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) cyc_r <= 0;
      else if (clk_en && cyc_r < 1000000) cyc_r <= cyc_r + 1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   chk_float_release: assert property ($rose(reset_n) |-> !serial_out_oe && !cmd_valid)
      else $error("output live at reset release");
   chk_float_idle: assert property (chip_select_n |-> !serial_out_oe)
      else $error("output driven while deselected");
   chk_quiet_early: assert property (!read_ready |-> !cmd_valid && !serial_out_oe && !frame_end)
      else $error("response before read delay");
   // one cycle of slack either side of the count, exact outside it
   chk_read_time: assert property (!(cyc_r inside {[READ_DELAY_CYC - 1 : READ_DELAY_CYC + 1]})
      |-> read_ready == (cyc_r > READ_DELAY_CYC)) else $error("read delay count wrong");
   chk_prog_time: assert property (!(cyc_r inside {[PROGRAM_DELAY_CYC - 1 : PROGRAM_DELAY_CYC + 1]})
      |-> program_ready == (cyc_r > PROGRAM_DELAY_CYC)) else $error("program delay count wrong");
   chk_reset_state: assert property (!program_ready |-> power_state == PWR_RESET)
      else $error("left reset state early");
   chk_standby_state: assert property ((program_ready && chip_select_n) [*5] |-> power_state == PWR_STANDBY)
      else $error("not in standby");
   chk_active_state: assert property ((program_ready && !chip_select_n) [*5] |-> power_state == PWR_ACTIVE)
      else $error("not active");
   chk_end_after: assert property (frame_end |-> chip_select_n && $past(chip_select_n, 2))
      else $error("frame end without select high");
   chk_mode_hold: assert property ($changed(spi_mode3) |-> !chip_select_n)
      else $error("mode changed while deselected");
   cover property (cmd_valid && spi_mode3);
   cover property (frame_end);
   cover property ($fell(serial_out_oe));
endmodule // flash_cmd_checker

bind flash_cmd_front flash_cmd_checker #(
   .READ_DELAY_CYC(READ_DELAY_CYC),
   .PROGRAM_DELAY_CYC(PROGRAM_DELAY_CYC)
) chk (.sys_clk, .reset_n, .clk_en, .chip_select_n, .serial_out_oe, .cmd_valid, .frame_end,
   .read_ready, .program_ready, .power_state, .spi_mode3);

//--- bench/spi_host_model.sv
// host controller model that frames commands towards the device
module spi_host_model (
   // link pins towards the device
   output logic serial_clk,
   output logic chip_select_n,
   output logic serial_in,
   // data returned by the device
   input wire logic serial_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];
   logic [7:0] sh;
   // deselected and still at time zero
   initial begin
      serial_clk = 1'h0;
      chip_select_n = 1'h1;
      serial_in = 1'h0;
   end
   // one frame at 64 ns per bit; bytes from index skip on are read back
   task automatic run(input logic m3, input int skip);
      serial_clk = m3;
      #100 chip_select_n = 1'h0;
      #64;
      foreach (tx_q[i]) begin
         for (int b = 7; b >= 0; b--) begin
            serial_clk = 1'h0;
            serial_in = tx_q[i][b];
            #32 serial_clk = 1'h1;
            sh = {sh[6:0], serial_out};
            #32;
         end
         if (i >= skip) rx_q.push_back(sh);
      end
      serial_clk = m3;
      // a released line must not keep its last value
      serial_in = ~serial_in;
      #32 chip_select_n = 1'h1;
      #100;
   endtask
endmodule // spi_host_model

//--- bench/serial_flash_cmd_power_on_test.sv
// self-checking bench for the serial flash command front end
module serial_flash_cmd_power_on_test import flash_cmd_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int RD = 20;
   localparam int PG = 50;
   logic sys_clk, reset_n, clk_en, serial_clk, chip_select_n, serial_in, serial_out, serial_out_oe;
   logic so_line;
   logic cmd_valid, frame_end, read_ready, program_ready, spi_mode3;
   logic [7:0] read_byte, cmd_opcode;
   logic [PAGE_ADDR_W-1:0] cmd_page_addr;
   logic [BYTE_ADDR_W-1:0] cmd_byte_addr;
   power_state_t power_state;
   int bad_count, compares, n_valid, n_end;
   logic [7:0] ops[10] = '{8'h01, 8'h03, 8'h0B, 8'h1B, 8'h9F, 8'hD2, 8'hD4, 8'hD6, 8'hD7, 8'h82};

   flash_cmd_front #(.READ_DELAY_CYC(RD), .PROGRAM_DELAY_CYC(PG)) uut (.sys_clk, .reset_n, .clk_en,
      .serial_clk, .chip_select_n, .serial_in, .serial_out, .serial_out_oe, .read_byte, .cmd_valid,
      .cmd_opcode, .cmd_page_addr, .cmd_byte_addr, .frame_end, .read_ready, .program_ready,
      .power_state, .spi_mode3);
   spi_host_model host (.serial_clk, .chip_select_n, .serial_in, .serial_out(so_line));
   // the data line floats unless driven; a pull-up holds it high then
   assign so_line = serial_out_oe ? serial_out : 1'h1;

   // 100 MHz system clock
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   // count the design's strobes
   always @(posedge sys_clk) begin
      if (cmd_valid === 1'h1) n_valid++;
      if (frame_end === 1'h1) n_end++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // one command; ok: 0 refused, 1 whole, 2 cut after the first address byte
   task automatic frame(input logic m3, input logic [7:0] op, input int ok);
      logic [23:0] a;
      int hdr, dum, nrd, v0, e0;
      a = 24'($urandom);
      hdr = (op == 8'h9F || op == 8'hD7) ? 1 : 4;
      case (op)
         8'h0B, 8'hD4, 8'hD6: dum = 1;
         8'h1B: dum = 2;
         8'hD2: dum = 4;
         default: dum = 0;
      endcase
      nrd = (op inside {8'h01, 8'h03, 8'h0B, 8'h1B, 8'h9F, 8'hD2, 8'hD4, 8'hD6, 8'hD7}) ? 2 : 0;
      v0 = n_valid;
      e0 = n_end;
      host.tx_q = {op, a[23:16], a[15:8], a[7:0]};
      if (hdr == 1) host.tx_q = {op};
      repeat (dum + nrd) host.tx_q.push_back(8'($urandom));
      if (ok == 2) host.tx_q = {op, a[23:16]};
      host.rx_q = {};
      @(negedge sys_clk) read_byte = 8'($urandom);
      host.run(m3, (ok == 2) ? 99 : hdr + dum);
      check(n_valid - v0, ok == 1);
      check(n_end - e0, ok != 0);
      foreach (host.rx_q[i]) check(host.rx_q[i], (ok == 1) ? read_byte : 8'hFF);
      if (ok == 1) begin
         check(host.rx_q.size(), nrd);
         check(cmd_opcode, op);
         check(spi_mode3, m3);
         if (hdr == 4) check({cmd_page_addr, cmd_byte_addr}, a[20:0]);
      end
   endtask

   // main sequence
   initial begin
      void'($urandom(32'h3cbe8375));
      reset_n = 1'h0;
      clk_en = 1'h1;
      read_byte = 8'h00;
      repeat (5) @(negedge sys_clk);
      reset_n = 1'h1;
      check(read_ready, 1'h0);
      check(power_state, PWR_RESET);
      // select falls before the read delay has run out
      frame(1'h0, 8'h0B, 0);
      // program opcodes only once the longer delay is over
      for (int i = 0; i < 200 && program_ready !== 1'h1; i++) @(negedge sys_clk);
      check(power_state, PWR_STANDBY);
      for (int m = 0; m < 2; m++) begin
         foreach (ops[i]) frame(m[0], ops[i], 1);
      end
      frame(1'h1, 8'h03, 2);
      // reset in mid-frame, select held low across the release
      @(negedge sys_clk);
      fork
         begin
            #300 reset_n = 1'h0;
            #30 reset_n = 1'h1;
            check(power_state, PWR_RESET);
            while (read_ready !== 1'h1) @(negedge sys_clk) clk_en = 1'($urandom);
            clk_en = 1'h1;
         end
         frame(1'h0, 8'h0B, 0);
      join
      frame(1'h1, 8'hD2, 1);
      conclude();
   end

   // cut a hang short; the sequence needs about a sixth of this
   initial begin
      #500000;
      bad_count++;
      conclude();
   end
endmodule // serial_flash_cmd_power_on_test
